// [rtl/dcf_pkg.sv]
package dcf_pkg;
    // ----------------------------------------------------------------
    // widths and sizes
    // ----------------------------------------------------------------
    localparam int DCF_SAMPLE_W = 20;
    localparam int DCF_COEF_W = 14;
    localparam int DCF_ADDR_W = 6;
    localparam int DCF_DEPTH = 64;
    localparam int DCF_TAP_W = 7;
    localparam int DCF_HIST = 128;
    localparam int DCF_ACC_W = 41;
    localparam int DCF_COEF_FRAC = 13;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] DCF_OFF_CTRL = 8'h00;
    localparam logic [7:0] DCF_OFF_TAPS = 8'h04;
    localparam logic [7:0] DCF_OFF_COFS = 8'h08;
    localparam logic [7:0] DCF_OFF_START = 8'h0C;
    localparam logic [7:0] DCF_OFF_STOP = 8'h10;
    localparam logic [7:0] DCF_OFF_COEF = 8'h14;
    localparam logic [7:0] DCF_OFF_STATUS = 8'h18;
    // ----------------------------------------------------------------
    // control fields and reset values
    // ----------------------------------------------------------------
    localparam int DCF_CTRL_W = 12;
    localparam int DCF_DEC_LSB = 0;
    localparam int DCF_PHASE_LSB = 4;
    localparam int DCF_BYPASS_BIT = 8;
    localparam int DCF_SCALE_LSB = 9;
    localparam int DCF_SYM_BIT = 11;
    localparam int DCF_BUSY_BIT = 8;
    localparam logic [11:0] DCF_CTRL_RST = 12'h600;
    localparam logic [6:0] DCF_TAPS_RST = 7'h00;
    localparam logic [5:0] DCF_ADDR_RST = 6'h00;
    // ----------------------------------------------------------------
    // filter engine states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DCF_IDLE = 3'b001,
        DCF_RUN = 3'b010,
        DCF_DONE = 3'b100
    } dcf_state_t;
endpackage

// [rtl/dcf_coef_ram.sv]
`timescale 1ns/1ns
module dcf_coef_ram import dcf_pkg::*; #(
    parameter int AW = DCF_ADDR_W,
    parameter int CW = DCF_COEF_W
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [CW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr_bus,
    output logic [CW-1:0] o_rdata_bus,
    input wire logic [AW-1:0] i_raddr_tap,
    output logic [CW-1:0] o_rdata_tap
);
    // one store per channel, read by bus and tap engine at once
    logic [CW-1:0] mem [2**AW];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata_bus = mem[i_raddr_bus];
    assign o_rdata_tap = mem[i_raddr_tap];
endmodule

// [rtl/dcf_mac.sv]
`timescale 1ns/1ns
module dcf_mac import dcf_pkg::*; #(
    parameter int SW = DCF_SAMPLE_W,
    parameter int CW = DCF_COEF_W,
    parameter int AW = DCF_ACC_W
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_clr,
    input wire logic i_en,
    input wire logic signed [SW-1:0] i_smp_i,
    input wire logic signed [SW-1:0] i_smp_q,
    input wire logic signed [CW-1:0] i_coef,
    output logic signed [AW-1:0] o_acc_i,
    output logic signed [AW-1:0] o_acc_q
);
    logic signed [AW-1:0] acc_i_d, acc_q_d, acc_i_q, acc_q_q;

    // one multiply per lane per clock
    always_comb begin
        acc_i_d = acc_i_q;
        acc_q_d = acc_q_q;
        if (i_clr) begin
            acc_i_d = '0;
            acc_q_d = '0;
        end else if (i_en) begin
            acc_i_d = acc_i_q + AW'(i_smp_i * i_coef);
            acc_q_d = acc_q_q + AW'(i_smp_q * i_coef);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            acc_i_q <= '0;
            acc_q_q <= '0;
        end else begin
            acc_i_q <= acc_i_d;
            acc_q_q <= acc_q_d;
        end
    end

    assign o_acc_i = acc_i_q;
    assign o_acc_q = acc_q_q;
endmodule

// [rtl/dcf_filter.sv]
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
// How it works
// - up to 64 asymmetric or 128 symmetric taps from a 64-entry coefficient store
// - four-bit field holds decimation factor minus one, factors 1 to 16
// - I and Q samples are 20 bits, coefficients 14 bits
// - tap count register holds taps minus one
// - bypass passes input unchanged with no scaling
// - scale 00/01/10/11 gives 18.06, 12.04, 6.02, 0 dB attenuation
// - symmetric mode stores half the response and mirrors it
// - coefficient offset selects which stored filter is active
// - offset change takes effect from the next output sample
// - four-bit decimation phase picks this channel's polyphase slot
// - outside bypass, output rate is input rate divided by decimation factor
// - one tap per clock per lane; taps limited by clock over output rate
// - each coefficient access advances pointer from start toward stop
// - equal start and stop confine access to a single entry
// - input rate equals helper filter rate; every input strobe is taken
module dcf_filter import dcf_pkg::*; #(
    parameter int SW = DCF_SAMPLE_W,
    parameter int CW = DCF_COEF_W
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    input wire logic i_in_valid,
    input wire logic signed [SW-1:0] i_in_i,
    input wire logic signed [SW-1:0] i_in_q,
    output logic o_out_valid,
    output logic signed [SW-1:0] o_out_i,
    output logic signed [SW-1:0] o_out_q
);
    // ----------------------------------------------------------------
    // bus slave and registers
    // ----------------------------------------------------------------
    logic wr_pend_d, wr_pend_q, rd_pend_d, rd_pend_q, hready_d, hready_q;
    logic [7:0] addr_d, addr_q;
    logic [31:0] hrdata_d, hrdata_q;
    logic [11:0] ctrl_d, ctrl_q;
    logic [6:0] taps_d, taps_q;
    logic [5:0] cofs_d, cofs_q, start_d, start_q, stop_d, stop_q, ptr_d, ptr_q;
    logic acc_ok, coef_acc, busy;
    logic [CW-1:0] ram_bus, ram_tap;
    logic [5:0] tap_addr;

    assign acc_ok = i_hsel && i_htrans[1] && i_hready;
    assign coef_acc = (wr_pend_q || rd_pend_q) && addr_q == DCF_OFF_COEF;

    always_comb begin
        wr_pend_d = acc_ok && i_hwrite;
        rd_pend_d = acc_ok && !i_hwrite;
        // reads take one wait state so a write just before is visible
        hready_d = !rd_pend_d;
        addr_d = acc_ok ? i_haddr[7:0] : addr_q;
        hrdata_d = hrdata_q;
        ctrl_d = ctrl_q;
        taps_d = taps_q;
        cofs_d = cofs_q;
        start_d = start_q;
        stop_d = stop_q;
        ptr_d = ptr_q;
        if (wr_pend_q) begin
            case (addr_q)
                DCF_OFF_CTRL: ctrl_d = i_hwdata[11:0];
                DCF_OFF_TAPS: taps_d = i_hwdata[6:0];
                DCF_OFF_COFS: cofs_d = i_hwdata[5:0];
                DCF_OFF_START: start_d = i_hwdata[5:0];
                DCF_OFF_STOP: stop_d = i_hwdata[5:0];
                default: ;
            endcase
        end
        if (rd_pend_q) begin
            case (addr_q)
                DCF_OFF_CTRL: hrdata_d = {20'h00000, ctrl_q};
                DCF_OFF_TAPS: hrdata_d = {25'h0000000, taps_q};
                DCF_OFF_COFS: hrdata_d = {26'h0000000, cofs_q};
                DCF_OFF_START: hrdata_d = {26'h0000000, start_q};
                DCF_OFF_STOP: hrdata_d = {26'h0000000, stop_q};
                DCF_OFF_COEF: hrdata_d = {18'h00000, ram_bus};
                DCF_OFF_STATUS: hrdata_d = {23'h000000, busy, 2'b00, ptr_q};
                default: hrdata_d = 32'h00000000;
            endcase
        end
        if (wr_pend_q && addr_q == DCF_OFF_START) begin
            ptr_d = i_hwdata[5:0];
        end else if (coef_acc && ptr_q != stop_q) begin
            ptr_d = 6'(ptr_q + 6'h01);
        end
        // pointer holds at stop, so start equal to stop stays put
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            hready_q <= 1'b1;
            addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
            ctrl_q <= DCF_CTRL_RST;
            taps_q <= DCF_TAPS_RST;
            cofs_q <= DCF_ADDR_RST;
            start_q <= DCF_ADDR_RST;
            stop_q <= DCF_ADDR_RST;
            ptr_q <= DCF_ADDR_RST;
        end else begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            hready_q <= hready_d;
            addr_q <= addr_d;
            hrdata_q <= hrdata_d;
            ctrl_q <= ctrl_d;
            taps_q <= taps_d;
            cofs_q <= cofs_d;
            start_q <= start_d;
            stop_q <= stop_d;
            ptr_q <= ptr_d;
        end
    end

    assign o_hreadyout = hready_q;
    assign o_hrdata = hrdata_q;
    assign o_hresp = 1'b0;

    dcf_coef_ram #(.AW(DCF_ADDR_W), .CW(CW)) u_ram (
        .i_clk(i_clk),
        .i_we(wr_pend_q && addr_q == DCF_OFF_COEF),
        .i_waddr(ptr_q),
        .i_wdata(i_hwdata[CW-1:0]),
        .i_raddr_bus(ptr_q),
        .o_rdata_bus(ram_bus),
        .i_raddr_tap(tap_addr),
        .o_rdata_tap(ram_tap)
    );

    // ----------------------------------------------------------------
    // sample history and decimation
    // ----------------------------------------------------------------
    logic signed [SW-1:0] hist_i [DCF_HIST];
    logic signed [SW-1:0] hist_q [DCF_HIST];
    logic [3:0] dec, phase_eff, grp_d, grp_q;
    logic trig;

    assign dec = ctrl_q[DCF_DEC_LSB +: 4];
    assign phase_eff = 4'({1'b0, ctrl_q[DCF_PHASE_LSB +: 4]} % ({1'b0, dec} + 5'h01));
    // one output start per group of dec+1 inputs
    assign trig = i_in_valid && grp_q == phase_eff;
    assign grp_d = !i_in_valid ? grp_q : (grp_q >= dec ? 4'h0 : 4'(grp_q + 4'h1));

    genvar g;
    generate
        for (g = 0; g < DCF_HIST; g++) begin : g_hist
            always_ff @(posedge i_clk) begin
                if (!i_resetn) begin
                    hist_i[g] <= '0;
                    hist_q[g] <= '0;
                end else if (i_in_valid) begin
                    hist_i[g] <= (g == 0) ? i_in_i : hist_i[(g == 0) ? 0 : g - 1];
                    hist_q[g] <= (g == 0) ? i_in_q : hist_q[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // tap engine
    // ----------------------------------------------------------------
    dcf_state_t state_d, state_q;
    logic [6:0] k_d, k_q, sh_d, sh_q, rtaps_d, rtaps_q;
    logic [5:0] rofs_d, rofs_q;
    logic rsym_d, rsym_q, mac_clr, mac_en;
    logic [1:0] rscale_d, rscale_q;
    logic [7:0] half, sidx, cidx;
    logic signed [SW-1:0] smp_i, smp_q;
    logic signed [DCF_ACC_W-1:0] acc_i, acc_q;

    assign busy = state_q != DCF_IDLE;
    assign half = 8'(({1'b0, rtaps_q} + 8'h02) >> 1);
    assign sidx = 8'({1'b0, k_q} + {1'b0, sh_q});
    // newer inputs during a run shift the history, so the index follows them
    assign smp_i = sidx[7] ? '0 : hist_i[sidx[6:0]];
    assign smp_q = sidx[7] ? '0 : hist_q[sidx[6:0]];

    always_comb begin
        if (rsym_q) begin
            // mirrored taps share one stored entry, middle first
            cidx = ({1'b0, k_q} < half) ? 8'(half - 8'h01 - {1'b0, k_q})
                : 8'({1'b0, k_q} - ({1'b0, rtaps_q} + 8'h01 - half));
        end else begin
            cidx = 8'({1'b0, rtaps_q} - {1'b0, k_q});
        end
        tap_addr = 6'(rofs_q + cidx[5:0]);
    end

    always_comb begin
        state_d = state_q;
        k_d = k_q;
        sh_d = sh_q;
        rtaps_d = rtaps_q;
        rofs_d = rofs_q;
        rsym_d = rsym_q;
        rscale_d = rscale_q;
        mac_clr = 1'b0;
        mac_en = 1'b0;
        case (state_q)
            DCF_IDLE: begin
                if (trig && !ctrl_q[DCF_BYPASS_BIT]) begin
                    state_d = DCF_RUN;
                    k_d = 7'h00;
                    sh_d = 7'h00;
                    rtaps_d = taps_q;
                    rofs_d = cofs_q;
                    rsym_d = ctrl_q[DCF_SYM_BIT];
                    rscale_d = ctrl_q[DCF_SCALE_LSB +: 2];
                    mac_clr = 1'b1;
                end
            end
            DCF_RUN: begin
                mac_en = 1'b1;
                if (i_in_valid && sh_q != 7'h7F) begin
                    sh_d = 7'(sh_q + 7'h01);
                end
                if (k_q == rtaps_q) begin
                    state_d = DCF_DONE;
                end else begin
                    k_d = 7'(k_q + 7'h01);
                end
            end
            DCF_DONE: state_d = DCF_IDLE;
            default: state_d = DCF_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_q <= DCF_IDLE;
            k_q <= 7'h00;
            sh_q <= 7'h00;
            rtaps_q <= DCF_TAPS_RST;
            rofs_q <= DCF_ADDR_RST;
            rsym_q <= 1'b0;
            rscale_q <= 2'b11;
            grp_q <= 4'h0;
        end else begin
            state_q <= state_d;
            k_q <= k_d;
            sh_q <= sh_d;
            rtaps_q <= rtaps_d;
            rofs_q <= rofs_d;
            rsym_q <= rsym_d;
            rscale_q <= rscale_d;
            grp_q <= grp_d;
        end
    end

    dcf_mac #(.SW(SW), .CW(CW), .AW(DCF_ACC_W)) u_mac (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clr(mac_clr),
        .i_en(mac_en),
        .i_smp_i(smp_i),
        .i_smp_q(smp_q),
        .i_coef(ram_tap),
        .o_acc_i(acc_i),
        .o_acc_q(acc_q)
    );

    // ----------------------------------------------------------------
    // output scaling and bypass
    // ----------------------------------------------------------------
    function automatic logic [SW-1:0] dcf_sat(input logic signed [DCF_ACC_W-1:0] v);
        logic signed [DCF_ACC_W-1:0] hi, lo;
        hi = DCF_ACC_W'(2 ** (SW - 1) - 1);
        lo = -hi - DCF_ACC_W'(1);
        if (v > hi) return hi[SW-1:0];
        if (v < lo) return lo[SW-1:0];
        return v[SW-1:0];
    endfunction

    logic [4:0] shamt;
    logic out_valid_d, out_valid_q;
    logic [SW-1:0] out_i_d, out_q_d, out_i_q, out_q_q;

    // coefficient full scale is one; each scale step is a further 6.02 dB
    assign shamt = 5'(DCF_COEF_FRAC) + 5'(2'b11 - rscale_q);

    always_comb begin
        out_valid_d = 1'b0;
        out_i_d = out_i_q;
        out_q_d = out_q_q;
        if (ctrl_q[DCF_BYPASS_BIT]) begin
            if (i_in_valid) begin
                out_valid_d = 1'b1;
                out_i_d = i_in_i;
                out_q_d = i_in_q;
            end
        end else if (state_q == DCF_DONE) begin
            out_valid_d = 1'b1;
            out_i_d = dcf_sat(acc_i >>> shamt);
            out_q_d = dcf_sat(acc_q >>> shamt);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            out_valid_q <= 1'b0;
            out_i_q <= '0;
            out_q_q <= '0;
        end else begin
            out_valid_q <= out_valid_d;
            out_i_q <= out_i_d;
            out_q_q <= out_q_d;
        end
    end

    assign o_out_valid = out_valid_q;
    assign o_out_i = out_i_q;
    assign o_out_q = out_q_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [7:0] run_cnt_q;
    always_ff @(posedge i_clk) begin
        if (!i_resetn || state_q != DCF_RUN) run_cnt_q <= 8'h00;
        else run_cnt_q <= 8'(run_cnt_q + 8'h01);
    end

    sequence s_start;
        state_q == DCF_IDLE && trig && !ctrl_q[DCF_BYPASS_BIT];
    endsequence
    property p_start;
        @(posedge i_clk) disable iff (!i_resetn) s_start |=> state_q == DCF_RUN && k_q == 7'h00;
    endproperty
    a_start: assert property (p_start) else $error("run did not start");
    property p_run_len;
        @(posedge i_clk) disable iff (!i_resetn)
            state_q == DCF_DONE |-> run_cnt_q == 8'({1'b0, rtaps_q} + 8'h01);
    endproperty
    a_run_len: assert property (p_run_len) else $error("tap count wrong");
    property p_ofs_held;
        @(posedge i_clk) disable iff (!i_resetn)
            state_q == DCF_RUN ##1 state_q != DCF_IDLE |-> $stable(rofs_q);
    endproperty
    a_ofs_held: assert property (p_ofs_held) else $error("offset moved mid sample");
    sequence s_last;
        state_q == DCF_RUN && k_q == rtaps_q;
    endsequence
    property p_done_out;
        @(posedge i_clk) disable iff (!i_resetn)
            s_last ##1 (state_q == DCF_DONE && !ctrl_q[DCF_BYPASS_BIT]) |=> o_out_valid;
    endproperty
    a_done_out: assert property (p_done_out) else $error("no output after run");
    property p_bypass;
        @(posedge i_clk) disable iff (!i_resetn)
            ctrl_q[DCF_BYPASS_BIT] && i_in_valid |=> o_out_valid && o_out_i == $past(i_in_i);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass altered data");
    property p_ptr_inc;
        @(posedge i_clk) disable iff (!i_resetn)
            coef_acc && ptr_q != stop_q && !(wr_pend_q && addr_q == DCF_OFF_START)
            |=> ptr_q == 6'($past(ptr_q) + 6'h01);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");
    property p_ptr_hold;
        @(posedge i_clk) disable iff (!i_resetn) coef_acc && ptr_q == stop_q |=> $stable(ptr_q);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer passed stop");
    property p_start_load;
        @(posedge i_clk) disable iff (!i_resetn)
            wr_pend_q && addr_q == DCF_OFF_START |=> ptr_q == $past(i_hwdata[5:0]);
    endproperty
    a_start_load: assert property (p_start_load) else $error("start not loaded");
    property p_sym_mid;
        @(posedge i_clk) disable iff (!i_resetn)
            state_q == DCF_RUN && rsym_q && k_q == rtaps_q |-> cidx == 8'(half - 8'h01);
    endproperty
    a_sym_mid: assert property (p_sym_mid) else $error("mirror end not at outer entry");
endmodule

// [sim/dcf_sample_src.sv]
`timescale 1ns/1ns
module dcf_sample_src (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_run,
    input wire logic [7:0] i_gap,
    output logic o_valid,
    output logic signed [19:0] o_i,
    output logic signed [19:0] o_q
);
    logic [7:0] cnt_q;
    int seed;
    initial begin
        seed = 32'h3f8b;
        cnt_q = 8'h00;
        o_valid = 1'b0;
        o_i = 20'h00000;
        o_q = 20'h00000;
    end
    // lines are inverted between samples so stale data never looks valid
    always @(posedge i_clk) begin
        if (!i_resetn || !i_run) begin
            o_valid <= 1'b0;
            cnt_q <= 8'h00;
            o_i <= ~o_i;
            o_q <= ~o_q;
        end else if (cnt_q == 8'h00) begin
            o_valid <= 1'b1;
            o_i <= 20'($random(seed));
            o_q <= 20'($random(seed));
            cnt_q <= i_gap;
        end else begin
            o_valid <= 1'b0;
            o_i <= ~o_i;
            o_q <= ~o_q;
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
    import dcf_pkg::*;
    logic i_clk, i_resetn, i_hsel, i_hwrite, hready, hresp, src_valid, out_valid, run;
    logic [31:0] i_haddr, i_hwdata, hrdata, x;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic [7:0] gap;
    logic signed [19:0] src_i, src_q, out_i, out_q;
    int mismatches, n_compared, seed, cyc, grp, e, m_ctrl, m_taps, m_off, m_ptr, m_stop;
    int hi[128], hq[128], mem[64], qi[$], qq[$], qt[$];
    int cc[7] = '{32'h600, 32'h023, 32'hA52, 32'hCFF, 32'h111, 32'h600, 32'hC00};
    int ct[7] = '{3, 19, 14, 15, 5, 63, 127};
    int co[7] = '{0, 0, 57, 56, 0, 0, 0};
    always #5 i_clk = ~i_clk;
    dcf_filter dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
        .i_in_valid(src_valid), .i_in_i(src_i), .i_in_q(src_q), .o_out_valid(out_valid),
        .o_out_i(out_i), .o_out_q(out_q));
    dcf_sample_src src (.i_clk(i_clk), .i_resetn(i_resetn), .i_run(run), .i_gap(gap),
        .o_valid(src_valid), .o_i(src_i), .o_q(src_q));
    function automatic int sat(longint v);
        if (v > 524287) return 524287;
        if (v < -524288) return -524288;
        return int'(v);
    endfunction
    // ----------------------------------------------------------------
    // reference model of the stream path
    // ----------------------------------------------------------------
    always @(posedge i_clk) begin : mdl
        int n, h, a, s, ei, eq, et;
        longint ai, aq;
        cyc = cyc + 1;
        if (!i_resetn) begin
            grp = 0;
            foreach (hi[k]) begin
                hi[k] = 0;
                hq[k] = 0;
            end
        end else if (src_valid === 1'b1) begin
            for (int k = 127; k > 0; k--) begin
                hi[k] = hi[k-1];
                hq[k] = hq[k-1];
            end
            hi[0] = src_i;
            hq[0] = src_q;
            // bypass forwards every input, decimation is skipped as well
            if (m_ctrl[8]) begin
                qi.push_back(src_i);
                qq.push_back(src_q);
                qt.push_back(cyc + 1);
            end else if (grp == ((m_ctrl >> 4) & 15) % ((m_ctrl & 15) + 1)) begin
                n = m_taps + 1;
                h = (n + 1) / 2;
                ai = 0;
                aq = 0;
                for (int k = 0; k < n; k++) begin
                    if (m_ctrl[11]) a = m_off + ((k < h) ? h - 1 - k : k - (n - h));
                    else a = m_off + m_taps - k;
                    ai += longint'(hi[k]) * mem[a & 63];
                    aq += longint'(hq[k]) * mem[a & 63];
                end
                s = 16 - ((m_ctrl >> 9) & 3);
                qi.push_back(sat(ai >>> s));
                qq.push_back(sat(aq >>> s));
                qt.push_back(cyc + m_taps + 3);
            end
            grp = (grp == (m_ctrl & 15)) ? 0 : grp + 1;
        end
        if (out_valid === 1'b1) begin
            if (qi.size() == 0) begin
                `CHK(out_valid, 1'b0)
            end else begin
                ei = qi.pop_front();
                eq = qq.pop_front();
                et = qt.pop_front();
                `CHK(out_i, 20'(ei))
                `CHK(out_q, 20'(eq))
                `CHK(cyc, et)
            end
        end
    end
    // ----------------------------------------------------------------
    // bus master and register helpers
    // ----------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'b10;
        i_haddr <= {24'h000000, a};
        i_hwrite <= wr;
        do @(posedge i_clk); while (hready !== 1'b1);
        i_hsel <= 1'b0;
        i_htrans <= 2'b00;
        i_hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic span(input int st, input int sp);
        bus(1'b1, DCF_OFF_START, 32'(st), x);
        bus(1'b1, DCF_OFF_STOP, 32'(sp), x);
        m_ptr = st;
        m_stop = sp;
    endtask
    // pointer holds at stop, so a single entry can be reached repeatedly
    task automatic coef(input logic wr, input int v, output int ev);
        bus(wr, DCF_OFF_COEF, 32'(v & 32'h3FFF), x); // whole word, never high byte first
        if (wr) mem[m_ptr] = (v & 32'h3FFF) - (((v >> 13) & 1) << 14);
        ev = mem[m_ptr] & 32'h3FFF;
        if (m_ptr != m_stop) m_ptr = (m_ptr + 1) & 63;
    endtask
    task automatic rst;
        i_resetn <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        m_ctrl = 32'h600;
        m_taps = 0;
        m_off = 0;
        m_ptr = 0;
        m_stop = 0;
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
    initial begin
        {i_clk, i_resetn, i_hsel, i_hwrite, run, cyc, grp, mismatches, n_compared} = '0;
        {i_haddr, i_hwdata, i_htrans, gap} = '0;
        i_hsize = 3'b010;
        seed = 32'h3f8b;
        rst();
        bus(1'b0, DCF_OFF_CTRL, 32'h0, x);
        `CHK(x, {20'h00000, DCF_CTRL_RST})
        bus(1'b1, 8'h1C, 32'hFFFFFFFF, x);
        bus(1'b0, 8'h1C, 32'h0, x);
        `CHK(x, 32'h00000000)
        `CHK(hresp, 1'b0)
        span(0, 63);
        for (int k = 0; k < 64; k++) coef(1'b1, $random(seed), e);
        bus(1'b0, DCF_OFF_STATUS, 32'h0, x);
        `CHK(x[5:0], 6'h3F)
        span(10, 12);
        for (int k = 0; k < 4; k++) begin
            coef(1'b0, 0, e);
            `CHK(x[13:0], 14'(e))
        end
        span(5, 5);
        coef(1'b1, $random(seed), e);
        coef(1'b0, 0, e);
        `CHK(x[13:0], 14'(e))
        bus(1'b0, DCF_OFF_STATUS, 32'h0, x);
        `CHK(x[5:0], 6'h05)
        for (int c = 0; c < 7; c++) begin
            rst();
            bus(1'b1, DCF_OFF_CTRL, 32'(cc[c]), x);
            bus(1'b1, DCF_OFF_TAPS, 32'(ct[c]), x);
            bus(1'b1, DCF_OFF_COFS, 32'(co[c]), x);
            {m_ctrl, m_taps, m_off} = {cc[c], ct[c], co[c]};
            gap <= 8'(ct[c] + 8);
            run <= 1'b1;
            repeat (2 * ((cc[c] & 15) + 1)) @(posedge i_clk iff src_valid === 1'b1);
            bus(1'b1, DCF_OFF_COFS, 32'(co[c] + 4), x);
            // the new offset is live only from the edge after the write lands
            m_off <= co[c] + 4;
            repeat (2 * ((cc[c] & 15) + 1)) @(posedge i_clk iff src_valid === 1'b1);
            run <= 1'b0;
            repeat (ct[c] + 12) @(posedge i_clk);
            `CHK(qi.size(), 0)
        end
        give_verdict();
    end
endmodule
